// ### verilog/x21cp_fsm.sv
// call-wait and call-progress state machine for the x.21 switched line
`timescale 1ns/100ps
`default_nettype none
// Operation
// - parity-error char: flag bit 7 selects handling
// - invalid char: flag bit 11 selects handling
// - in 06B drive T one, C on
// - enter 06B from 09/10bis on accept
// - T4 two seconds from 09, expiry clears
// - valid dce info char in 06B: 10bis
// - steady R one enters state 11
// - steady R one and I on: 12
// - abort or fatal error enters state 16
// - network clear: state 19, terminate, report
// - in 07 drive T one, C on
// - numeric char in 06A enters 07
// - plus ends block, not stored
// - signals are two digits, comma separated
// - T2 twenty seconds from 05, expiry clears
// - T3A two seconds, restarted per detection
// - first char zero selects 60 s T3B
// - terminator then two SYN returns 06A
// - enter 06A from 05/07/10 on initiate
module x21cp_fsm #(
    parameter logic [31:0] T2_CYCLES = x21cp_pkg::T2_CYC,
    parameter logic [31:0] T3A_CYCLES = x21cp_pkg::T3A_CYC,
    parameter logic [31:0] T3B_CYCLES = x21cp_pkg::T3B_CYC,
    parameter logic [31:0] T4_CYCLES = x21cp_pkg::T4_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic r_pin,
    input wire logic i_pin,
    input wire logic rx_valid,
    input wire logic [6:0] rx_char,
    input wire logic rx_parity_err,
    input wire logic [15:0] receive_error_handling_flags,
    input wire logic [1:0] dce_info_character_set,
    input wire logic cmd_open_initiate,
    input wire logic cmd_open_accept,
    input wire logic cmd_abort,
    input wire logic cmd_cp_dump,
    input wire logic charge_info_call,
    input wire logic fatal_error,
    input wire logic net_clear,
    input wire logic sig_state05,
    input wire logic sig_state09,
    input wire logic det_state10,
    input wire logic enter_06a,
    input wire logic enter_06b,
    input wire logic call_release,
    output logic t_out,
    output logic c_on,
    output x21cp_pkg::x21cp_state_e call_state,
    output logic terminate_reqs,
    output logic err_valid,
    output logic [3:0] err_code,
    output logic char_tossed,
    output logic timeout,
    output logic cp_valid,
    output logic [6:0] cp_data,
    output logic cp_last
);
    x21cp_pkg::x21cp_state_e st_r, st_nxt;
    logic r_meta_r, r_sync_r, i_meta_r, i_sync_r;
    logic [7:0] r_cnt_r, i_cnt_r;
    logic r_steady, i_steady;
    logic open_pend_r, init_pend_r;
    logic term_seen_r;
    logic [1:0] syn_cnt_r;
    logic [1:0] cp_pos_r;
    logic t3b_sel_r;
    logic [x21cp_pkg::CP_AW-1:0] wr_ptr_r, rd_ptr_r;
    logic dump_act_r, dump_vld_r, dump_last_r;
    logic t2_exp, t3_exp, t4_exp, any_exp;
    logic is_digit, is_syn, is_comma, is_plus, is_dce_info;
    logic active, toss, invalid, good, t3_start, cp_we;
    logic [6:0] rd_data;

    // two-flop synchronisers for the network circuits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_meta_r <= 1'b0;
            r_sync_r <= 1'b0;
            i_meta_r <= 1'b0;
            i_sync_r <= 1'b0;
        end else begin
            r_meta_r <= r_pin;
            r_sync_r <= r_meta_r;
            i_meta_r <= i_pin;
            i_sync_r <= i_meta_r;
        end
    end

    // steady-level filters; a glitch restarts the count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_cnt_r <= 8'h0;
            i_cnt_r <= 8'h0;
        end else begin
            r_cnt_r <= !r_sync_r ? 8'h0 : (r_steady ? r_cnt_r : r_cnt_r + 8'h1);
            i_cnt_r <= !i_sync_r ? 8'h0 : (i_steady ? i_cnt_r : i_cnt_r + 8'h1);
        end
    end
    assign r_steady = (r_cnt_r >= x21cp_pkg::STEADY_CYC);
    assign i_steady = (i_cnt_r >= x21cp_pkg::STEADY_CYC);

    // character classes
    assign is_digit = (rx_char >= x21cp_pkg::CH_ZERO) && (rx_char <= x21cp_pkg::CH_NINE);
    assign is_syn = (rx_char == x21cp_pkg::CH_SYN);
    assign is_comma = (rx_char == x21cp_pkg::CH_COMMA);
    assign is_plus = (rx_char == x21cp_pkg::CH_PLUS);
    // bit 0 admits digits, bit 1 other printables as dce information
    assign is_dce_info = (is_digit && dce_info_character_set[0])
        || (!is_digit && !is_syn && rx_char >= x21cp_pkg::CH_PRN_LO
            && rx_char <= x21cp_pkg::CH_PRN_HI && dce_info_character_set[1]);
    assign active = (st_r == x21cp_pkg::ST_06A) || (st_r == x21cp_pkg::ST_06B)
        || (st_r == x21cp_pkg::ST_07);
    // r at one or a clear under way means the char is a line transition
    assign toss = r_sync_r || net_clear;

    // what each waiting state accepts
    always_comb begin
        invalid = 1'b0;
        case (st_r)
            x21cp_pkg::ST_06A: invalid = !is_digit && !is_syn;
            x21cp_pkg::ST_06B: invalid = !is_syn && !is_dce_info;
            x21cp_pkg::ST_07: begin
                if (is_syn) begin
                    invalid = 1'b0;
                end else if (cp_pos_r == 2'd2) begin
                    invalid = !is_comma && !is_plus;
                end else begin
                    invalid = !is_digit;
                end
            end
            default: invalid = 1'b0;
        endcase
    end
    assign good = rx_valid && !rx_parity_err && !invalid && !toss;

    // next state, clearing and expiry ahead of line events
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            x21cp_pkg::ST_IDLE, x21cp_pkg::ST_10BIS: begin
                if (enter_06b && (cmd_open_accept || charge_info_call)) begin
                    st_nxt = x21cp_pkg::ST_06B;
                end else if (enter_06a && init_pend_r) begin
                    st_nxt = x21cp_pkg::ST_06A;
                end
            end
            x21cp_pkg::ST_11: begin
                if (i_steady) begin
                    st_nxt = x21cp_pkg::ST_12;
                end
            end
            x21cp_pkg::ST_12, x21cp_pkg::ST_16, x21cp_pkg::ST_19: begin
                if (call_release) begin
                    st_nxt = x21cp_pkg::ST_IDLE;
                end
            end
            default: begin
                if (good && st_r == x21cp_pkg::ST_06A && is_digit && init_pend_r) begin
                    st_nxt = x21cp_pkg::ST_07;
                end else if (good && st_r == x21cp_pkg::ST_06B && is_dce_info) begin
                    st_nxt = x21cp_pkg::ST_10BIS;
                end else if (good && st_r == x21cp_pkg::ST_07 && is_syn && term_seen_r
                             && syn_cnt_r == 2'(x21cp_pkg::SYN_EXIT - 1)) begin
                    st_nxt = x21cp_pkg::ST_06A;
                end
            end
        endcase
        if (active && r_steady) begin
            st_nxt = i_steady ? x21cp_pkg::ST_12 : x21cp_pkg::ST_11;
        end
        if (st_r != x21cp_pkg::ST_12 && st_r != x21cp_pkg::ST_16 && st_r != x21cp_pkg::ST_19
            && (any_exp || fatal_error || (cmd_abort && open_pend_r))) begin
            st_nxt = x21cp_pkg::ST_16;
        end
        if (net_clear && st_r != x21cp_pkg::ST_19) begin
            st_nxt = x21cp_pkg::ST_19;
        end
    end

    // state register and circuit drive
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= x21cp_pkg::ST_IDLE;
            t_out <= 1'b1;
            c_on <= 1'b0;
        end else begin
            st_r <= st_nxt;
            // dte clear request drops both; waiting states hold T one, C on
            t_out <= (st_nxt != x21cp_pkg::ST_16) && (st_nxt != x21cp_pkg::ST_19);
            c_on <= (st_nxt != x21cp_pkg::ST_IDLE) && (st_nxt != x21cp_pkg::ST_16)
                && (st_nxt != x21cp_pkg::ST_19);
        end
    end
    assign call_state = st_r;

    // open commands pending until the call is released, cleared or reaches state 12
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            open_pend_r <= 1'b0;
            init_pend_r <= 1'b0;
        end else if (cmd_open_initiate || cmd_open_accept) begin
            open_pend_r <= 1'b1;
            init_pend_r <= cmd_open_initiate;
        end else if (call_release || st_nxt == x21cp_pkg::ST_16
                     || st_nxt == x21cp_pkg::ST_19 || st_nxt == x21cp_pkg::ST_12) begin
            open_pend_r <= 1'b0;
            init_pend_r <= 1'b0;
        end
    end

    // call-progress parser: position, terminator and syn count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cp_pos_r <= 2'd0;
            term_seen_r <= 1'b0;
            syn_cnt_r <= 2'd0;
            t3b_sel_r <= 1'b0;
        end else if (st_r == x21cp_pkg::ST_06A && st_nxt == x21cp_pkg::ST_07) begin
            cp_pos_r <= 2'd1;
            term_seen_r <= 1'b0;
            syn_cnt_r <= 2'd0;
            t3b_sel_r <= (rx_char == x21cp_pkg::CH_ZERO);
        end else if (st_r == x21cp_pkg::ST_07 && good) begin
            if (is_syn) begin
                syn_cnt_r <= term_seen_r ? syn_cnt_r + 2'd1 : 2'd0;
            end else if (is_plus) begin
                term_seen_r <= 1'b1;
                cp_pos_r <= 2'd0;
            end else begin
                term_seen_r <= 1'b0;
                syn_cnt_r <= 2'd0;
                cp_pos_r <= (cp_pos_r == 2'd2) ? 2'd0 : cp_pos_r + 2'd1;
            end
        end
    end

    // buffer digits and commas; the plus never reaches the buffer
    assign cp_we = good && ((st_r == x21cp_pkg::ST_06A && st_nxt == x21cp_pkg::ST_07)
        || (st_r == x21cp_pkg::ST_07 && (is_digit || is_comma)));

    // write pointer saturates: excess signals are lost, not wrapped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
        end else if (cmd_open_initiate) begin
            wr_ptr_r <= '0;
        end else if (cp_we && wr_ptr_r != '1) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // dump streams the buffer, one char a cycle after read latency
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dump_act_r <= 1'b0;
            rd_ptr_r <= '0;
            dump_vld_r <= 1'b0;
            dump_last_r <= 1'b0;
            cp_valid <= 1'b0;
            cp_last <= 1'b0;
            cp_data <= 7'h0;
        end else begin
            dump_vld_r <= dump_act_r;
            dump_last_r <= dump_act_r && (rd_ptr_r + 1'b1 == wr_ptr_r);
            cp_valid <= dump_vld_r;
            cp_last <= dump_last_r;
            cp_data <= dump_vld_r ? rd_data : 7'h0;
            if (cmd_cp_dump && !dump_act_r && wr_ptr_r != '0) begin
                dump_act_r <= 1'b1;
                rd_ptr_r <= '0;
            end else if (dump_act_r) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                dump_act_r <= (rd_ptr_r + 1'b1 != wr_ptr_r);
            end
        end
    end

    x21cp_cpbuf u_cpbuf (
        .sys_clk(sys_clk),
        .we(cp_we),
        .waddr(wr_ptr_r),
        .wdata(rx_char),
        .raddr(rd_ptr_r),
        .rdata(rd_data)
    );

    // garbled chars: flag bit chooses report or silent discard
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_valid <= 1'b0;
            err_code <= 4'h0;
            char_tossed <= 1'b0;
            terminate_reqs <= 1'b0;
            timeout <= 1'b0;
        end else begin
            err_valid <= 1'b0;
            char_tossed <= 1'b0;
            timeout <= any_exp && st_nxt == x21cp_pkg::ST_16;
            terminate_reqs <= (st_nxt == x21cp_pkg::ST_19) && (st_r != x21cp_pkg::ST_19);
            if (st_nxt == x21cp_pkg::ST_19 && st_r != x21cp_pkg::ST_19) begin
                err_valid <= 1'b1;
                err_code <= x21cp_pkg::ERR_DISCONNECT;
            end else if (active && rx_valid && (rx_parity_err || invalid)) begin
                if (toss) begin
                    char_tossed <= 1'b1;
                end else if (rx_parity_err) begin
                    err_valid <= receive_error_handling_flags[x21cp_pkg::FLG_PARITY];
                    char_tossed <= !receive_error_handling_flags[x21cp_pkg::FLG_PARITY];
                    err_code <= x21cp_pkg::ERR_PARITY;
                end else begin
                    err_valid <= receive_error_handling_flags[x21cp_pkg::FLG_INVALID];
                    char_tossed <= !receive_error_handling_flags[x21cp_pkg::FLG_INVALID];
                    err_code <= x21cp_pkg::ERR_INVALID;
                end
            end
        end
    end

    // call timers, counts set by parameters and loaded on start; 12, 16, 19 close the enum and halt them
    assign t3_start = (st_r != x21cp_pkg::ST_07 && st_nxt == x21cp_pkg::ST_07) || det_state10;
    assign any_exp = t2_exp || t3_exp || t4_exp;

    x21cp_timer u_t2 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(sig_state05),
        .load_val(T2_CYCLES),
        .stop(st_r >= x21cp_pkg::ST_12),
        .expired(t2_exp)
    );
    x21cp_timer u_t3 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(t3_start),
        .load_val((t3b_sel_r || (t3_start && rx_char == x21cp_pkg::CH_ZERO && rx_valid))
            ? T3B_CYCLES : T3A_CYCLES),
        .stop(st_r >= x21cp_pkg::ST_12),
        .expired(t3_exp)
    );
    x21cp_timer u_t4 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(sig_state09),
        .load_val(T4_CYCLES),
        .stop(st_r >= x21cp_pkg::ST_12),
        .expired(t4_exp)
    );

    chk_clear_on_net: assert property (@(posedge sys_clk) disable iff (!arst_n)
        net_clear && st_r != x21cp_pkg::ST_19 |=> st_r == x21cp_pkg::ST_19
        ##0 terminate_reqs) else $error("network clear did not reach state 19");
    chk_abort_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
        active && cmd_abort && open_pend_r && !net_clear |=> st_r == x21cp_pkg::ST_16
        ##1 !t_out && !c_on) else $error("abort did not clear");
    chk_wait_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r == x21cp_pkg::ST_06B || st_r == x21cp_pkg::ST_07) && $stable(st_r)
        |-> t_out && c_on) else $error("waiting state drive wrong");
    chk_steady_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
        active && r_steady && !i_steady && !net_clear && !any_exp && !fatal_error && !cmd_abort
        |=> st_r == x21cp_pkg::ST_11) else $error("steady R did not give 11");
    chk_ready_data: assert property (@(posedge sys_clk) disable iff (!arst_n)
        active && r_steady && i_steady && !net_clear && !any_exp && !fatal_error && !cmd_abort
        |=> st_r == x21cp_pkg::ST_12) else $error("steady R and I did not give 12");
    chk_digit_to_cp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r == x21cp_pkg::ST_06A && good && is_digit && init_pend_r && !r_steady && !any_exp
        && !fatal_error && !cmd_abort |=> st_r == x21cp_pkg::ST_07)
        else $error("digit in 06A ignored");
    chk_parity_report: assert property (@(posedge sys_clk) disable iff (!arst_n)
        active && rx_valid && rx_parity_err && !toss && !net_clear
        |=> err_valid == $past(receive_error_handling_flags[7])
        && err_valid != char_tossed) else $error("parity handling wrong");
    chk_invalid_report: assert property (@(posedge sys_clk) disable iff (!arst_n)
        active && rx_valid && !rx_parity_err && invalid && !toss && !net_clear
        |=> err_valid == $past(receive_error_handling_flags[11])
        ##0 err_code == 4'h2 || !err_valid) else $error("invalid handling wrong");
    chk_plus_unbuffered: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rx_valid && is_plus |-> !cp_we) else $error("terminator buffered");
    chk_syn_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r == x21cp_pkg::ST_07 && $past(st_r) == x21cp_pkg::ST_07 && st_nxt == x21cp_pkg::ST_06A
        |-> term_seen_r && is_syn) else $error("left 07 without terminator");
endmodule
`default_nettype wire

// ### verilog/x21cp_pkg.sv
// constants and state type for the call-wait and call-progress machine
package x21cp_pkg;
    // clock
    localparam int unsigned CLK_HZ = 25000000;
    // timer nominal durations in ms and derived cycle counts
    localparam int unsigned T2_MS = 20000;
    localparam int unsigned T3A_MS = 2000;
    localparam int unsigned T3B_MS = 60000;
    localparam int unsigned T4_MS = 2000;
    localparam logic [31:0] T2_CYC = 32'(64'(T2_MS) * 64'(CLK_HZ) / 64'd1000);
    localparam logic [31:0] T3A_CYC = 32'(64'(T3A_MS) * 64'(CLK_HZ) / 64'd1000);
    localparam logic [31:0] T3B_CYC = 32'(64'(T3B_MS) * 64'(CLK_HZ) / 64'd1000);
    localparam logic [31:0] T4_CYC = 32'(64'(T4_MS) * 64'(CLK_HZ) / 64'd1000);
    // least time a circuit must hold before it counts as steady
    localparam int unsigned STEADY_NS = 2000;
    localparam logic [7:0] STEADY_CYC = 8'((STEADY_NS * 25 + 999) / 1000);
    // ia5 characters of interest
    localparam logic [6:0] CH_SYN = 7'h16;
    localparam logic [6:0] CH_PLUS = 7'h2b;
    localparam logic [6:0] CH_COMMA = 7'h2c;
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_NINE = 7'h39;
    localparam logic [6:0] CH_PRN_LO = 7'h20;
    localparam logic [6:0] CH_PRN_HI = 7'h7e;
    // receive error handling flag positions
    localparam int unsigned FLG_PARITY = 7;
    localparam int unsigned FLG_INVALID = 11;
    // error report codes
    localparam logic [3:0] ERR_PARITY = 4'h1;
    localparam logic [3:0] ERR_INVALID = 4'h2;
    localparam logic [3:0] ERR_DISCONNECT = 4'h8;
    // call-progress buffer
    localparam int unsigned CP_AW = 5;
    localparam int unsigned CP_DEPTH = 32;
    localparam int unsigned SYN_EXIT = 2;
    typedef enum logic [3:0] {
        ST_IDLE, ST_06A, ST_06B, ST_07, ST_10BIS, ST_11, ST_12, ST_16, ST_19
    } x21cp_state_e;
endpackage

// ### verilog/x21cp_timer.sv
// down-counting call timer, reloaded from load_val on each start
`timescale 1ns/100ps
`default_nettype none
module x21cp_timer (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [31:0] load_val,
    input wire logic stop,
    output logic expired
);
    logic [31:0] cnt_r;
    logic run_r;
    logic exp_r;

    // stop outranks start, so a late restart cannot revive a finished call
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 32'h0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            exp_r <= 1'b0;
            if (stop) begin
                run_r <= 1'b0;
            end else if (start) begin
                cnt_r <= load_val;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (cnt_r <= 32'h1) begin
                    run_r <= 1'b0;
                    exp_r <= 1'b1; // one-cycle expiry pulse
                end else begin
                    cnt_r <= cnt_r - 32'h1;
                end
            end
        end
    end
    assign expired = exp_r;
endmodule
`default_nettype wire

// ### verilog/x21cp_cpbuf.sv
// small buffer for call-progress characters, registered read data
`timescale 1ns/100ps
`default_nettype none
module x21cp_cpbuf (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [x21cp_pkg::CP_AW-1:0] waddr,
    input wire logic [6:0] wdata,
    input wire logic [x21cp_pkg::CP_AW-1:0] raddr,
    output logic [6:0] rdata
);
    logic [6:0] mem [x21cp_pkg::CP_DEPTH];
    logic [6:0] rd_r;

    // plain ram, no reset so it maps to block memory
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rd_r <= mem[raddr];
    end
    assign rdata = rd_r;
endmodule
`default_nettype wire

// ### sim/x21cp_dce.sv
// behavioural network-side model: R and I circuits and received characters
`timescale 1ns/100ps
`default_nettype none
module x21cp_dce (
    input wire logic sys_clk,
    output logic r_pin,
    output logic i_pin,
    output logic rx_valid,
    output logic [6:0] rx_char,
    output logic rx_parity_err
);
    // idle: R at 0, I off
    initial begin
        r_pin = 1'b0;
        i_pin = 1'b0;
        rx_valid = 1'b0;
        rx_char = 7'h00;
        rx_parity_err = 1'b0;
    end
    // one ia5 char, I off; data inverted after the strobe
    task automatic send(input logic [6:0] c, input logic p);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_parity_err <= p;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        rx_parity_err <= ~p;
    endtask
    // steady levels on R and I
    task automatic lines(input logic r, input logic i);
        @(posedge sys_clk);
        r_pin <= r;
        i_pin <= i;
    endtask
endmodule
`default_nettype wire

// ### sim/x21_call_wait_progress_fsm_tb.sv
// self-checking bench for the call-wait and call-progress machine
`timescale 1ns/100ps
`default_nettype none
module x21_call_wait_progress_fsm_tb;
    localparam logic [12:0] E_INI = 13'h0001, E_ACC = 13'h0002, E_ABT = 13'h0004;
    localparam logic [12:0] E_DMP = 13'h0008, E_CHG = 13'h0010, E_FAT = 13'h0020;
    localparam logic [12:0] E_CLR = 13'h0040, E_S05 = 13'h0080, E_S09 = 13'h0100;
    localparam logic [12:0] E_D10 = 13'h0200, E_06A = 13'h0400, E_06B = 13'h0800;
    localparam logic [12:0] E_REL = 13'h1000;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [12:0] ev = 13'h0000;
    logic [15:0] flags = 16'h0000;
    logic r_pin, i_pin, rx_valid, rx_perr, t_out, c_on, term, err_valid, tossed, tmo;
    logic cp_valid, cp_last;
    logic [6:0] rx_char, cp_data;
    logic [3:0] err_code;
    x21cp_pkg::x21cp_state_e st;
    logic err_seen = 1'b0, toss_seen = 1'b0, to_seen = 1'b0, term_seen = 1'b0;
    logic [3:0] err_last = 4'h0;
    logic [7:0] cp_q[$];
    int miscompares = 0;
    int checks = 0;
    always #20 sys_clk = ~sys_clk;
    x21cp_dce i_dce (.sys_clk(sys_clk), .r_pin(r_pin), .i_pin(i_pin), .rx_valid(rx_valid),
        .rx_char(rx_char), .rx_parity_err(rx_perr));
    // short timer counts keep the run brief
    x21cp_fsm #(.T2_CYCLES(32'd200), .T3A_CYCLES(32'd50), .T3B_CYCLES(32'd400),
        .T4_CYCLES(32'd50)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .r_pin(r_pin),
        .i_pin(i_pin), .rx_valid(rx_valid), .rx_char(rx_char), .rx_parity_err(rx_perr),
        .receive_error_handling_flags(flags), .dce_info_character_set(2'h1),
        .cmd_open_initiate(ev[0]), .cmd_open_accept(ev[1]), .cmd_abort(ev[2]),
        .cmd_cp_dump(ev[3]), .charge_info_call(ev[4]), .fatal_error(ev[5]),
        .net_clear(ev[6]), .sig_state05(ev[7]), .sig_state09(ev[8]), .det_state10(ev[9]),
        .enter_06a(ev[10]), .enter_06b(ev[11]), .call_release(ev[12]), .t_out(t_out),
        .c_on(c_on), .call_state(st), .terminate_reqs(term), .err_valid(err_valid),
        .err_code(err_code), .char_tossed(tossed), .timeout(tmo), .cp_valid(cp_valid),
        .cp_data(cp_data), .cp_last(cp_last));
    // one-cycle pulses are caught here so the tasks need not hit their exact cycle
    always @(posedge sys_clk) begin
        if (err_valid === 1'b1) begin
            err_seen <= 1'b1;
            err_last <= err_code;
        end
        if (tossed === 1'b1) toss_seen <= 1'b1;
        if (tmo === 1'b1) to_seen <= 1'b1;
        if (term === 1'b1) term_seen <= 1'b1;
        if (cp_valid === 1'b1) cp_q.push_back({cp_last, cp_data});
    end
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clr();
        @(negedge sys_clk);
        {err_seen, toss_seen, to_seen, term_seen} = 4'h0;
    endtask
    task automatic fire(input logic [12:0] v);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= 13'h0000;
    endtask
    // bounded wait for a state; running out of cycles ends the run
    task automatic wait_st(input x21cp_pkg::x21cp_state_e s, input int n);
        int k;
        k = 0;
        while (st !== s && k < n) begin
            @(negedge sys_clk);
            k++;
        end
        chk("call_state", 8'(st), 8'(s));
        if (st !== s) finish_test();
    endtask
    task automatic t_progress();
        clr();
        fire(E_INI | E_S05);
        fire(E_06A);
        wait_st(x21cp_pkg::ST_06A, 8);
        i_dce.send(7'h34, 1'b0);
        wait_st(x21cp_pkg::ST_07, 8);
        chk("t_c", {t_out, c_on}, 8'h03);
        i_dce.send(7'h31, 1'b0);
        i_dce.send(7'h2b, 1'b0);
        i_dce.send(7'h16, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk("one_syn", 8'(st), 8'(x21cp_pkg::ST_07));
        i_dce.send(7'h16, 1'b0);
        wait_st(x21cp_pkg::ST_06A, 8);
        cp_q.delete();
        fire(E_DMP);
        repeat (8) @(negedge sys_clk);
        chk("cp_count", 8'(cp_q.size()), 8'h02);
        chk("cp_pair", {cp_q[0][3:0], cp_q[1][3:0]}, 8'h41);
        chk("cp_last", {cp_q[0][7], cp_q[1][7]}, 8'h01);
        fire(E_ABT);
        wait_st(x21cp_pkg::ST_16, 8);
        chk("t_c_16", {t_out, c_on}, 8'h00);
        fire(E_REL);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        $display("test progress done");
    endtask
    task automatic t_errors();
        @(posedge sys_clk);
        flags <= 16'h0880;
        clr();
        fire(E_INI);
        fire(E_06A);
        wait_st(x21cp_pkg::ST_06A, 8);
        i_dce.send(7'h35, 1'b1);
        repeat (3) @(negedge sys_clk);
        chk("parity_code", {err_seen, err_last}, 8'h11);
        i_dce.send(7'h39, 1'b0);
        wait_st(x21cp_pkg::ST_07, 8);
        clr();
        i_dce.send(7'h2c, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk("invalid_code", {err_seen, err_last}, 8'h12);
        @(posedge sys_clk);
        flags <= 16'h0000;
        clr();
        i_dce.send(7'h35, 1'b1);
        repeat (3) @(negedge sys_clk);
        chk("discard", {err_seen, toss_seen}, 8'h01);
        fire(E_FAT);
        wait_st(x21cp_pkg::ST_16, 8);
        fire(E_REL);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        $display("test errors done");
    endtask
    task automatic t_answer();
        clr();
        fire(E_ACC | E_06B | E_S09);
        wait_st(x21cp_pkg::ST_06B, 8);
        chk("t_c", {t_out, c_on}, 8'h03);
        i_dce.send(7'h35, 1'b0);
        wait_st(x21cp_pkg::ST_10BIS, 8);
        wait_st(x21cp_pkg::ST_16, 80);
        fire(E_REL | E_D10);
        chk("t4_expiry", 8'(to_seen), 8'h01);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        fire(E_CHG | E_06B);
        wait_st(x21cp_pkg::ST_06B, 8);
        i_dce.lines(1'b1, 1'b1);
        wait_st(x21cp_pkg::ST_12, 80);
        chk("t_c_12", {t_out, c_on}, 8'h03);
        i_dce.lines(1'b0, 1'b0);
        fire(E_REL);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        $display("test answer done");
    endtask
    task automatic t_long();
        clr();
        fire(E_INI);
        fire(E_06A);
        wait_st(x21cp_pkg::ST_06A, 8);
        i_dce.send(7'h30, 1'b0);
        wait_st(x21cp_pkg::ST_07, 8);
        i_dce.lines(1'b1, 1'b0);
        repeat (60) @(negedge sys_clk);
        chk("r_steady", 8'(st), 8'(x21cp_pkg::ST_11));
        wait_st(x21cp_pkg::ST_16, 400);
        i_dce.lines(1'b0, 1'b0);
        fire(E_REL);
        chk("t3b_expiry", 8'(to_seen), 8'h01);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        clr();
        fire(E_S05);
        wait_st(x21cp_pkg::ST_16, 220);
        fire(E_REL);
        chk("t2_expiry", 8'(to_seen), 8'h01);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        fire(E_INI);
        fire(E_06A);
        wait_st(x21cp_pkg::ST_06A, 8);
        clr();
        fire(E_CLR);
        wait_st(x21cp_pkg::ST_19, 8);
        repeat (2) @(negedge sys_clk);
        chk("disconnect", {term_seen, err_last}, 8'h18);
        fire(E_REL);
        wait_st(x21cp_pkg::ST_IDLE, 8);
        $display("test long done");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_progress();
        t_errors();
        t_answer();
        t_long();
        finish_test();
    end
endmodule
`default_nettype wire
